// ===== shared/acc_pkg.sv
// Constants and types for the analog comparator control block
package acc_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] MASK_OFFSET   = 8'h08;

    // Control register field positions
    localparam int ENABLE_BIT    = 15;
    localparam int PIN_DRIVE_BIT = 14;
    localparam int INVERT_BIT    = 13;
    localparam int READBACK_BIT  = 8;
    localparam int EDGE_HI_BIT   = 7;
    localparam int EDGE_LO_BIT   = 6;
    localparam int POS_SEL_BIT   = 4;
    localparam int NEG_HI_BIT    = 1;
    localparam int NEG_LO_BIT    = 0;

    // Status and mask field position
    localparam int EVENT_BIT = 0;

    // Event edge select codes
    localparam logic [1:0] EDGE_NONE    = 2'h0;
    localparam logic [1:0] EDGE_RISING  = 2'h1;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

    // Input routing codes
    localparam logic       POS_PIN_A    = 1'h0;
    localparam logic       POS_LADDER   = 1'h1;
    localparam logic [1:0] NEG_PIN_B    = 2'h0;
    localparam logic [1:0] NEG_PIN_C    = 2'h1;
    localparam logic [1:0] NEG_PIN_D    = 2'h2;
    localparam logic [1:0] NEG_BANDGAP  = 2'h3;

    // Writable control fields
    typedef struct packed {
        logic       enable;
        logic       pinDrive;
        logic       invert;
        logic [1:0] edgeSel;
        logic       posSel;
        logic [1:0] negSel;
    } acc_ctrl_type;

    // Routing handed to the analog multiplexers
    typedef struct packed {
        logic       posSel;
        logic [1:0] negSel;
    } acc_route_type;

    // Values after reset
    localparam acc_ctrl_type CTRL_RESET = '{
        enable:   1'h0,
        pinDrive: 1'h0,
        invert:   1'h0,
        edgeSel:  EDGE_BOTH,
        posSel:   POS_PIN_A,
        negSel:   NEG_BANDGAP
    };
    localparam logic STATUS_RESET = 1'h0;
    localparam logic MASK_RESET   = 1'h0;

endpackage

// ===== src/acc_edge_detect.sv
// Result synchroniser, polarity adjust and edge detector
`timescale 1ns/1ps
module acc_edge_detect
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // Raw result and controls
    input  wire logic rawResult,
    input  wire logic invert,
    input  wire logic enable,
    // Adjusted result and edges
    output logic      adjusted,
    output logic      rising,
    output logic      falling
);

    logic syncFirst_q;
    logic syncSecond_q;
    logic adjusted_q;
    logic adjusted_d;

    // Disabled comparator reads low; inversion feeds edges too
    assign adjusted_d = enable & (syncSecond_q ^ invert);

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            syncFirst_q  <= 1'h0;
            syncSecond_q <= 1'h0;
            adjusted_q   <= 1'h0;
        end
        else
        begin
            syncFirst_q  <= rawResult;
            syncSecond_q <= syncFirst_q;
            adjusted_q   <= adjusted_d;
        end
    end

    assign adjusted = adjusted_q;
    assign rising   = adjusted_d & ~adjusted_q;
    assign falling  = ~adjusted_d & adjusted_q;

    property p_adjust;
        @(posedge clock) disable iff (!reset_n)
        enable |=> adjusted_q == ($past(syncSecond_q) ^ $past(invert));
    endproperty
    a_adjust : assert property (p_adjust)
        else $error("Adjusted result does not follow inversion");

endmodule // acc_edge_detect

// ===== src/acc_top.sv
// Analog comparator control register, routing and event logic
//
// Function
// - Setting the enable bit powers the comparator and writes all other fields too.
// - Clearing the enable bit powers it down and writes all other fields too.
// - The pin drive bit puts the result on the result pin, else not.
// - The invert bit inverts the result before any use of it.
// - The read-only readback bit shows the result and ignores writes.
// - Edge select 01 events on rising, 10 on falling, 11 on both edges.
// - Edge select 00 raises no comparator event at all.
// - Inversion also feeds edge detection, swapping the edge selected.
// - Positive select 1 picks the ladder reference, 0 external input A.
// - Negative select 00/01/10/11 picks pin B, C, D or the band gap.
// - Unimplemented control bits always read as zero.
`timescale 1ns/1ps
module acc_top
(
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    // Register port
    input  wire logic [7:0]             busAddr,
    input  wire logic [31:0]            busWrData,
    input  wire logic                   busWrite,
    input  wire logic                   busRead,
    output logic      [31:0]            busRdData,
    // Comparator core
    input  wire logic                   compRawResult,
    output logic                        compEnable,
    output acc_pkg::acc_route_type      compRoute,
    // Result pin
    output logic                        resultPin,
    output logic                        resultPinOe,
    // Events
    output logic                        eventPulse,
    output logic                        irq
);

    // Registers
    acc_pkg::acc_ctrl_type ctrl_q;
    acc_pkg::acc_ctrl_type ctrl_d;
    logic                  status_q;
    logic                  status_d;
    logic                  mask_q;
    logic                  mask_d;
    logic [31:0]           rdData_q;
    logic [31:0]           rdData_d;
    logic                  eventPulse_q;
    logic                  irq_q;
    logic                  irq_d;
    logic                  resultPin_q;
    logic                  resultPinOe_q;
    logic                  compEnable_q;
    acc_pkg::acc_route_type route_q;
    acc_pkg::acc_route_type route_d;

    // Decode
    logic        ctrlHit;
    logic        statusHit;
    logic        maskHit;
    logic        ctrlWrite;
    logic        maskWrite;
    logic        statusRead;
    logic [31:0] ctrlWord;
    logic [31:0] statusWord;
    logic [31:0] maskWord;
    logic [31:0] readMux;
    acc_pkg::acc_ctrl_type wrFields;

    // Result path
    logic adjusted;
    logic rising;
    logic falling;
    logic edgeHit;

    // Address decode
    assign ctrlHit    = busAddr == acc_pkg::CTRL_OFFSET;
    assign statusHit  = busAddr == acc_pkg::STATUS_OFFSET;
    assign maskHit    = busAddr == acc_pkg::MASK_OFFSET;
    assign ctrlWrite  = busWrite & ctrlHit;
    assign maskWrite  = busWrite & maskHit;
    assign statusRead = busRead & statusHit;

    // Write data unpacked into fields; readback bit not stored
    assign wrFields.enable   = busWrData[acc_pkg::ENABLE_BIT];
    assign wrFields.pinDrive = busWrData[acc_pkg::PIN_DRIVE_BIT];
    assign wrFields.invert   = busWrData[acc_pkg::INVERT_BIT];
    assign wrFields.edgeSel  =
        busWrData[acc_pkg::EDGE_HI_BIT:acc_pkg::EDGE_LO_BIT];
    assign wrFields.posSel   = busWrData[acc_pkg::POS_SEL_BIT];
    assign wrFields.negSel   =
        busWrData[acc_pkg::NEG_HI_BIT:acc_pkg::NEG_LO_BIT];

    // A control write replaces every stored field at once
    assign ctrl_d = ctrlWrite ? wrFields : ctrl_q;

    // Read words; unused positions are constant zero
    assign ctrlWord = {16'h0000,
                       ctrl_q.enable,
                       ctrl_q.pinDrive,
                       ctrl_q.invert,
                       4'h0,
                       adjusted,
                       ctrl_q.edgeSel,
                       1'h0,
                       ctrl_q.posSel,
                       2'h0,
                       ctrl_q.negSel};
    assign statusWord = {31'h00000000, status_q};
    assign maskWord   = {31'h00000000, mask_q};

    assign readMux = ctrlHit   ? ctrlWord   :
                     statusHit ? statusWord :
                     maskHit   ? maskWord   :
                                 32'h00000000;

    // Read data stand only in the cycle after the strobe
    assign rdData_d = busRead ? readMux : 32'h00000000;

    // Result synchroniser and edge detector
    acc_edge_detect u_edge
    (
        .clock     (clock),
        .reset_n   (reset_n),
        .rawResult (compRawResult),
        .invert    (ctrl_q.invert),
        .enable    (ctrl_q.enable),
        .adjusted  (adjusted),
        .rising    (rising),
        .falling   (falling)
    );

    // Edge qualification by the select field
    assign edgeHit = (ctrl_q.edgeSel[0] & rising) |
                     (ctrl_q.edgeSel[1] & falling);

    // Sticky event: a new event wins over the read clear
    assign status_d = (status_q & ~statusRead) | edgeHit;
    assign mask_d   = maskWrite ? busWrData[acc_pkg::EVENT_BIT] : mask_q;
    assign irq_d    = status_d & mask_d;

    // Routing follows the stored selects
    assign route_d.posSel = ctrl_q.posSel;
    assign route_d.negSel = ctrl_q.negSel;

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            ctrl_q   <= acc_pkg::CTRL_RESET;
            status_q <= acc_pkg::STATUS_RESET;
            mask_q   <= acc_pkg::MASK_RESET;
            rdData_q <= 32'h00000000;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            status_q <= status_d;
            mask_q   <= mask_d;
            rdData_q <= rdData_d;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            eventPulse_q  <= 1'h0;
            irq_q         <= 1'h0;
            resultPin_q   <= 1'h0;
            resultPinOe_q <= 1'h0;
            compEnable_q  <= 1'h0;
            route_q       <= '{posSel: acc_pkg::CTRL_RESET.posSel,
                               negSel: acc_pkg::CTRL_RESET.negSel};
        end
        else
        begin
            eventPulse_q  <= edgeHit;
            irq_q         <= irq_d;
            resultPin_q   <= ctrl_q.pinDrive & adjusted;
            resultPinOe_q <= ctrl_q.pinDrive;
            compEnable_q  <= ctrl_q.enable;
            route_q       <= route_d;
        end
    end

    assign busRdData   = rdData_q;
    assign compEnable  = compEnable_q;
    assign compRoute   = route_q;
    assign resultPin   = resultPin_q;
    assign resultPinOe = resultPinOe_q;
    assign eventPulse  = eventPulse_q;
    assign irq         = irq_q;

    // Checks

    property p_enable_on;
        @(posedge clock) disable iff (!reset_n)
        (ctrlWrite && busWrData[acc_pkg::ENABLE_BIT]) ##1 !ctrlWrite
        |=> compEnable_q
            && ctrl_q.negSel == $past(busWrData[1:0], 2)
            && ctrl_q.edgeSel == $past(busWrData[7:6], 2);
    endproperty
    a_enable_on : assert property (p_enable_on)
        else $error("Enable write did not power comparator");

    property p_enable_off;
        @(posedge clock) disable iff (!reset_n)
        (ctrl_q.enable && ctrlWrite && !busWrData[acc_pkg::ENABLE_BIT])
        ##1 !ctrlWrite
        |=> !compEnable_q
            && ctrl_q.pinDrive == $past(busWrData[14], 2)
            && ctrl_q.posSel == $past(busWrData[4], 2);
    endproperty
    a_enable_off : assert property (p_enable_off)
        else $error("Disable write wrong");

    property p_pin_drive;
        @(posedge clock) disable iff (!reset_n)
        !ctrl_q.pinDrive [*2] |-> !resultPinOe_q && !resultPin_q;
    endproperty
    a_pin_drive : assert property (p_pin_drive)
        else $error("Result pin driven while drive disabled");

    property p_pin_value;
        @(posedge clock) disable iff (!reset_n)
        ctrl_q.pinDrive |=> resultPinOe_q && resultPin_q == $past(adjusted);
    endproperty
    a_pin_value : assert property (p_pin_value)
        else $error("Result pin does not carry result");

    property p_readback;
        @(posedge clock) disable iff (!reset_n)
        (busRead && ctrlHit)
        |=> busRdData[acc_pkg::READBACK_BIT] == $past(adjusted);
    endproperty
    a_readback : assert property (p_readback)
        else $error("Readback bit does not show result");

    property p_edge_kind;
        @(posedge clock) disable iff (!reset_n)
        eventPulse_q |-> ($past(ctrl_q.edgeSel[0]) && $past(rising))
                      || ($past(ctrl_q.edgeSel[1]) && $past(falling));
    endproperty
    a_edge_kind : assert property (p_edge_kind)
        else $error("Event pulse on unselected edge");

    property p_no_events;
        @(posedge clock) disable iff (!reset_n)
        (ctrl_q.edgeSel == acc_pkg::EDGE_NONE) |=> !eventPulse_q;
    endproperty
    a_no_events : assert property (p_no_events)
        else $error("Event pulse with events disabled");

    property p_route;
        @(posedge clock) disable iff (!reset_n)
        ctrlWrite ##1 !ctrlWrite
        |=> compRoute.negSel == $past(busWrData[1:0], 2)
            && compRoute.posSel == $past(busWrData[4], 2);
    endproperty
    a_route : assert property (p_route)
        else $error("Input routing does not follow control");

    property p_zero_bits;
        @(posedge clock) disable iff (!reset_n)
        (busRead && ctrlHit) |=> busRdData[31:16] == 16'h0000
            && busRdData[12:9] == 4'h0
            && !busRdData[5]
            && busRdData[3:2] == 2'h0;
    endproperty
    a_zero_bits : assert property (p_zero_bits)
        else $error("Unimplemented control bit reads nonzero");

    property p_sticky;
        @(posedge clock) disable iff (!reset_n)
        eventPulse_q |-> status_q && (irq_q == mask_q);
    endproperty
    a_sticky : assert property (p_sticky)
        else $error("Event pulse did not set status");

endmodule // acc_top

// ===== testbench/acc_comp_model.sv
// Behavioural comparator core with its input multiplexers
`timescale 1ns/1ps
module acc_comp_model
(
    // Clock
    input  wire logic                   clock,
    // Controls from the block
    input  wire logic                   compEnable,
    input  wire acc_pkg::acc_route_type compRoute,
    // Input levels as codes: A, B, C, D, ladder, band gap
    input  wire logic [7:0]             lvlA,
    input  wire logic [7:0]             lvlB,
    input  wire logic [7:0]             lvlC,
    input  wire logic [7:0]             lvlD,
    input  wire logic [7:0]             lvlLadder,
    input  wire logic [7:0]             lvlBandgap,
    // Core output
    output logic                        rawResult
);
    logic       noise_q = 1'b0;
    logic [7:0] posLevel;
    logic [7:0] negLevel;

    assign posLevel = compRoute.posSel ? lvlLadder : lvlA;
    assign negLevel = (compRoute.negSel == acc_pkg::NEG_PIN_B) ? lvlB :
                      (compRoute.negSel == acc_pkg::NEG_PIN_C) ? lvlC :
                      (compRoute.negSel == acc_pkg::NEG_PIN_D) ? lvlD :
                      lvlBandgap;

    // Powered-down core gives no valid result
    always @(posedge clock)
        noise_q <= ~noise_q;
    assign rawResult = compEnable ? (posLevel > negLevel) : noise_q;
endmodule // acc_comp_model

// ===== testbench/acc_top_tb.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module acc_top_tb;
    localparam logic [7:0] CTRL = acc_pkg::CTRL_OFFSET;
    localparam logic [7:0] STAT = acc_pkg::STATUS_OFFSET;
    localparam logic [7:0] MASK = acc_pkg::MASK_OFFSET;
    logic                   clock = 1'b0;
    logic                   reset_n = 1'b0;
    logic [7:0]             busAddr = 8'h00;
    logic [31:0]            busWrData = 32'h0;
    logic                   busWrite = 1'b0;
    logic                   busRead = 1'b0;
    logic [31:0]            busRdData;
    logic                   compRawResult;
    logic                   compEnable;
    acc_pkg::acc_route_type compRoute;
    logic                   resultPin;
    logic                   resultPinOe;
    logic                   eventPulse;
    logic                   irq;
    logic [7:0]             lvl [6];
    logic [63:0]            expQ [$];
    logic [63:0]            note;
    logic [31:0]            ctl;
    logic                   rdSeen = 1'b0;
    logic                   expBit;
    integer                 seed = 32'h1dd0;
    int                     n_mismatch = 0;
    int                     compares = 0;
    int                     nPulse = 0;
    int                     cycles = 0;
    int                     i;

    always #12.5 clock = ~clock;

    acc_top i_acc_top (.clock(clock), .reset_n(reset_n), .busAddr(busAddr),
        .busWrData(busWrData), .busWrite(busWrite), .busRead(busRead),
        .busRdData(busRdData), .compRawResult(compRawResult),
        .compEnable(compEnable), .compRoute(compRoute),
        .resultPin(resultPin), .resultPinOe(resultPinOe),
        .eventPulse(eventPulse), .irq(irq));

    acc_comp_model i_acc_comp_model (.clock(clock), .compEnable(compEnable),
        .compRoute(compRoute), .lvlA(lvl[0]), .lvlB(lvl[1]), .lvlC(lvl[2]),
        .lvlD(lvl[3]), .lvlLadder(lvl[4]), .lvlBandgap(lvl[5]),
        .rawResult(compRawResult));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One bus cycle; a read notes its expected word and care mask
    task automatic busOp(input logic wr, input logic [7:0] a,
                         input logic [31:0] d, input logic [31:0] m);
        @(posedge clock);
        busAddr <= a;
        busWrData <= d;
        if (wr)
            busWrite <= 1'b1;
        else
        begin
            busRead <= 1'b1;
            expQ.push_back({m, d});
        end
        @(posedge clock);
        busWrite <= 1'b0;
        busRead <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        busOp(1'b1, a, d, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        busOp(1'b0, a, e, 32'hffffffff);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    function automatic logic res(input logic p, input logic [1:0] n);
        logic [7:0] pl;
        pl = p ? lvl[4] : lvl[0];
        return pl > lvl[(n == 2'h3) ? 5 : n + 1];
    endfunction

    // Read data watcher and event counter
    always @(posedge clock)
    begin
        cycles = cycles + 1;
        if (eventPulse === 1'b1)
            nPulse = nPulse + 1;
        if (rdSeen && expQ.size() > 0)
        begin
            note = expQ.pop_front();
            check(busRdData & note[63:32], note[31:0]);
        end
        rdSeen <= busRead;
        if (cycles == 4000)
        begin
            n_mismatch = n_mismatch + 1;
            report_and_stop();
        end
    end

    initial
    begin
        for (i = 0; i < 6; i++)
            lvl[i] = 8'($random(seed));
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        rd(CTRL, 32'h000000c3);
        rd(STAT, 32'h0);
        rd(MASK, 32'h0);
        wr(8'h0c, 32'hffffffff);
        rd(8'h0c, 32'h0);
        wr(CTRL, 32'hffff7fff);
        rd(CTRL, 32'h000060d3);
        // Every input route with random levels
        for (i = 0; i < 8; i++)
        begin
            ctl = 32'h00008000 | (32'(i[2]) << 4) | 32'(i[1:0]);
            wr(CTRL, ctl);
            settle(6);
            check(32'(compRoute), 32'(i[2:0]));
            check(32'(compEnable), 32'h1);
            rd(CTRL, ctl | (32'(res(i[2], i[1:0])) << 8));
        end
        // Pin drive and inversion, then power down
        lvl[0] <= 8'h10;
        lvl[1] <= 8'h80;
        wr(CTRL, 32'h0000c000);
        settle(6);
        check(32'({resultPinOe, resultPin}), 32'h2);
        wr(CTRL, 32'h0000e000);
        settle(6);
        check(32'({resultPinOe, resultPin}), 32'h3);
        rd(CTRL, 32'h0000e100);
        wr(CTRL, 32'h00002000);
        settle(6);
        check(32'({compEnable, resultPinOe, resultPin}), 32'h0);
        rd(CTRL, 32'h00002000);
        // Each edge code with and without inversion on a rising result
        wr(MASK, 32'h1);
        for (i = 0; i < 8; i++)
        begin
            lvl[0] <= 8'h10;
            wr(CTRL, 32'h00008000 | (32'(i[0]) << 13) | (32'(i[2:1]) << 6));
            settle(6);
            busOp(1'b0, STAT, 32'h0, 32'hfffffffe);
            settle(2);
            nPulse = 0;
            lvl[0] <= 8'hf0;
            settle(6);
            expBit = i[0] ? i[2] : i[1];
            check(32'(nPulse), 32'(expBit));
            check(32'(irq), 32'(expBit));
            rd(STAT, 32'(expBit));
        end
        // Masked event, unmask, then clear by reading
        wr(MASK, 32'h0);
        lvl[0] <= 8'h10;
        settle(6);
        check(32'(irq), 32'h0);
        wr(MASK, 32'h1);
        settle(2);
        check(32'(irq), 32'h1);
        rd(MASK, 32'h1);
        rd(STAT, 32'h1);
        settle(3);
        check(32'(irq), 32'h0);
        report_and_stop();
    end
endmodule // acc_top_tb
